/* scan_host_if.sv */
// parallel host bus between host end and device end
interface scan_host_if;
	logic access_strobe_n; // low while an access is in progress
	logic read_select; // high for read, low for write
	logic [2:0] addr; // register index
	logic [7:0] host_data_out; // host drive value
	logic host_data_oe; // host drives the bus
	logic [7:0] dev_data_out; // device drive value
	logic dev_data_oe; // device drives the bus
	logic ready; // low stalls the access
	logic [7:0] data_bus; // resolved bus level
	// device wins; an undriven bus reads all ones (pullups)
	assign data_bus = dev_data_oe ? dev_data_out :
		(host_data_oe ? host_data_out : 8'hff);
	modport device (input access_strobe_n, input read_select, input addr,
		input data_bus, output dev_data_out, output dev_data_oe,
		output ready);
	modport host (output access_strobe_n, output read_select,
		output addr, output host_data_out, output host_data_oe,
		input data_bus, input ready);
endinterface // scan_host_if

/* scan_port_device.sv */
// device end: register file and strobe handshake
module scan_port_device (
	input wire logic clock,
	input wire logic rst_n,
	scan_host_if.device bus,
	input wire logic in_buffer_empty_flag,
	input wire logic out_buffer_full_flag,
	input wire logic counter_state_flag,
	input wire logic [1:0] tap_state_field_a,
	input wire logic [1:0] present_state_field,
	input wire logic [7:0] incoming_data,
	input wire logic full_duplex_active,
	input wire logic command_done,
	output logic [7:0] config_main,
	output logic [7:0] config_clock_delay,
	output logic [7:0] scan_command,
	output logic [7:0] cycle_counter,
	output logic [7:0] direct_pin_control,
	output logic [7:0] outgoing_data,
	output logic outgoing_write,
	output logic incoming_read,
	output logic command_write,
	output logic soft_reset
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, // no access
		ST_WAIT = 2'b01, // access stalled, ready low
		ST_SERVE = 2'b10 // access granted, waiting rising strobe
	} port_state_t;

	port_state_t state_reg, state_next;
	logic strobe_reg, strobe_next; // strobe seen at the last edge
	logic [2:0] addr_reg, addr_next; // address latched at falling edge
	logic read_reg, read_next; // direction latched at falling edge
	logic ready_reg, ready_next;
	logic [7:0] dout_reg, dout_next;
	logic doe_reg, doe_next;
	logic [2:0] lead_reg, lead_next; // writes minus reads in full duplex
	logic [7:0] cfg_main_reg, cfg_main_next;
	logic [7:0] cfg_delay_reg, cfg_delay_next;
	logic [7:0] cmd_reg, cmd_next;
	logic [7:0] out_buf_reg, out_buf_next;
	logic [7:0] counter_reg, counter_next;
	logic [7:0] direct_reg, direct_next;
	logic out_wr_reg, out_wr_next;
	logic in_rd_reg, in_rd_next;
	logic cmd_wr_reg, cmd_wr_next;
	logic sreset_reg, sreset_next;
	logic fall, rise; // strobe edges in the clock domain
	logic busy; // opcode non-zero
	logic lead_hit; // retiming lead limit reached
	logic blocked; // latched access cannot proceed now
	logic [7:0] status_word;
	logic [7:0] read_word;

	assign status_word = {in_buffer_empty_flag, out_buffer_full_flag,
		counter_state_flag, 1'b0, tap_state_field_a, present_state_field};
	assign busy = cmd_reg[scan_port_pkg::OPCODE_MSB:0] != 4'h0;
	assign lead_hit = full_duplex_active &&
		(cfg_delay_reg[scan_port_pkg::RETIME_MSB:0] != 4'h0) &&
		(lead_reg >= scan_port_pkg::LEAD_LIMIT);
	assign fall = strobe_reg && !bus.access_strobe_n;
	assign rise = !strobe_reg && bus.access_strobe_n;
	// decide whether the latched access must stall
	always_comb begin
		blocked = 1'b0;
		if (read_reg) begin
			blocked = (addr_reg == scan_port_pkg::ADDR_INCOMING_BUFFER) &&
				in_buffer_empty_flag;
		end else begin
			case (addr_reg)
				scan_port_pkg::ADDR_OUTGOING_BUFFER: begin
					blocked = out_buffer_full_flag || lead_hit;
				end
				scan_port_pkg::ADDR_SCAN_COMMAND: begin
					blocked = busy &&
						!bus.data_bus[scan_port_pkg::SOFT_RESET_BIT];
				end
				// status and incoming are read only, never stall
				scan_port_pkg::ADDR_PORT_STATUS,
				scan_port_pkg::ADDR_INCOMING_BUFFER: blocked = 1'b0;
				default: blocked = busy;
			endcase
		end
	end

	always_comb begin
		case (addr_reg)
			scan_port_pkg::ADDR_CONFIG_MAIN: read_word = cfg_main_reg;
			scan_port_pkg::ADDR_CONFIG_CLOCK_DELAY: read_word = cfg_delay_reg;
			scan_port_pkg::ADDR_PORT_STATUS: read_word = status_word;
			scan_port_pkg::ADDR_SCAN_COMMAND: read_word = cmd_reg;
			scan_port_pkg::ADDR_OUTGOING_BUFFER: read_word = out_buf_reg;
			scan_port_pkg::ADDR_INCOMING_BUFFER: read_word = incoming_data;
			scan_port_pkg::ADDR_CYCLE_COUNTER: read_word = counter_reg;
			default: read_word = direct_reg;
		endcase
	end

	// next state of the handshake and register file
	always_comb begin
		state_next = state_reg;
		strobe_next = bus.access_strobe_n;
		addr_next = addr_reg;
		read_next = read_reg;
		ready_next = ready_reg;
		dout_next = dout_reg;
		doe_next = doe_reg;
		lead_next = full_duplex_active ? lead_reg : 3'h0;
		cfg_main_next = cfg_main_reg;
		cfg_delay_next = cfg_delay_reg;
		cmd_next = cmd_reg;
		out_buf_next = out_buf_reg;
		counter_next = counter_reg;
		direct_next = direct_reg;
		out_wr_next = 1'b0;
		in_rd_next = 1'b0;
		cmd_wr_next = 1'b0;
		sreset_next = 1'b0;
		// engine finishing a command clears the opcode
		if (command_done) cmd_next[scan_port_pkg::OPCODE_MSB:0] = 4'h0;
		case (state_reg)
			ST_IDLE: begin
				if (fall) begin
					addr_next = bus.addr;
					read_next = bus.read_select;
					state_next = ST_WAIT;
					ready_next = 1'b0;
				end
			end
			ST_WAIT: begin
				if (rise) begin
					// abandoned stalled access is discarded
					state_next = ST_IDLE;
					ready_next = 1'b1;
				end else if (!blocked) begin
					state_next = ST_SERVE;
					ready_next = 1'b1;
					if (read_reg) begin
						dout_next = read_word;
						doe_next = 1'b1;
						if (addr_reg == scan_port_pkg::ADDR_INCOMING_BUFFER) begin
							in_rd_next = 1'b1;
							if (lead_reg != 3'h0) lead_next = lead_reg - 3'h1;
						end
					end
				end
			end
			ST_SERVE: begin
				if (rise) begin
					doe_next = 1'b0;
					state_next = ST_IDLE;
					if (!read_reg) begin
						case (addr_reg)
							scan_port_pkg::ADDR_CONFIG_MAIN: begin
								cfg_main_next = bus.data_bus &
									scan_port_pkg::MASK_CONFIG_MAIN;
							end
							scan_port_pkg::ADDR_CONFIG_CLOCK_DELAY: begin
								cfg_delay_next = bus.data_bus &
									scan_port_pkg::MASK_CLOCK_DELAY;
							end
							scan_port_pkg::ADDR_SCAN_COMMAND: begin
								cmd_wr_next = 1'b1;
								cmd_next = bus.data_bus;
								if (bus.data_bus[scan_port_pkg::SOFT_RESET_BIT]) begin
									sreset_next = 1'b1;
									cmd_next = scan_port_pkg::RESET_OTHER;
									cfg_main_next = scan_port_pkg::RESET_OTHER;
									cfg_delay_next = scan_port_pkg::RESET_CLOCK_DELAY;
									counter_next = scan_port_pkg::RESET_OTHER;
									direct_next = scan_port_pkg::RESET_OTHER;
									out_buf_next = scan_port_pkg::RESET_OTHER;
									lead_next = 3'h0;
								end
							end
							scan_port_pkg::ADDR_OUTGOING_BUFFER: begin
								out_buf_next = bus.data_bus;
								out_wr_next = 1'b1;
								if (full_duplex_active) begin
									lead_next = lead_reg + 3'h1;
								end
							end
							scan_port_pkg::ADDR_CYCLE_COUNTER: begin
								counter_next = bus.data_bus;
							end
							scan_port_pkg::ADDR_DIRECT_PIN_CONTROL: begin
								direct_next = bus.data_bus &
									scan_port_pkg::MASK_DIRECT_PIN;
							end
							// status and incoming writes are ignored
							default: cmd_wr_next = 1'b0;
						endcase
					end
				end
			end
			default: state_next = ST_IDLE;
		endcase
	end
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			strobe_reg <= 1'b1;
			addr_reg <= 3'h0;
			read_reg <= 1'b0;
			ready_reg <= 1'b1;
			dout_reg <= 8'h00;
			doe_reg <= 1'b0;
			lead_reg <= 3'h0;
			cfg_main_reg <= scan_port_pkg::RESET_OTHER;
			cfg_delay_reg <= scan_port_pkg::RESET_CLOCK_DELAY;
			cmd_reg <= scan_port_pkg::RESET_OTHER;
			out_buf_reg <= scan_port_pkg::RESET_OTHER;
			counter_reg <= scan_port_pkg::RESET_OTHER;
			direct_reg <= scan_port_pkg::RESET_OTHER;
			out_wr_reg <= 1'b0;
			in_rd_reg <= 1'b0;
			cmd_wr_reg <= 1'b0;
			sreset_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			strobe_reg <= strobe_next;
			addr_reg <= addr_next;
			read_reg <= read_next;
			ready_reg <= ready_next;
			dout_reg <= dout_next;
			doe_reg <= doe_next;
			lead_reg <= lead_next;
			cfg_main_reg <= cfg_main_next;
			cfg_delay_reg <= cfg_delay_next;
			cmd_reg <= cmd_next;
			out_buf_reg <= out_buf_next;
			counter_reg <= counter_next;
			direct_reg <= direct_next;
			out_wr_reg <= out_wr_next;
			in_rd_reg <= in_rd_next;
			cmd_wr_reg <= cmd_wr_next;
			sreset_reg <= sreset_next;
		end
	end

	assign bus.dev_data_out = dout_reg;
	assign bus.dev_data_oe = doe_reg;
	assign bus.ready = ready_reg;
	assign config_main = cfg_main_reg;
	assign config_clock_delay = cfg_delay_reg;
	assign scan_command = cmd_reg;
	assign cycle_counter = counter_reg;
	assign direct_pin_control = direct_reg;
	assign outgoing_data = out_buf_reg;
	assign outgoing_write = out_wr_reg;
	assign incoming_read = in_rd_reg;
	assign command_write = cmd_wr_reg;
	assign soft_reset = sreset_reg;
endmodule // scan_port_device

/* scan_port_host.sv */
// host end: turns one-cycle orders into strobed accesses
module scan_port_host (
	input wire logic clock,
	input wire logic rst_n,
	scan_host_if.host bus,
	input wire logic [2:0] cmd_addr,
	input wire logic [7:0] cmd_wdata,
	input wire logic cmd_write,
	input wire logic cmd_read,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic busy
);
	typedef enum logic [1:0] {
		HS_IDLE = 2'b00, // bus quiet
		HS_HOLD = 2'b01, // strobe low, device not yet answered
		HS_WAIT = 2'b10, // watching ready
		HS_END = 2'b11 // strobe high, data still held one cycle
	} host_state_t;

	host_state_t state_reg, state_next;
	logic strobe_reg, strobe_next;
	logic read_reg, read_next;
	logic [2:0] addr_reg, addr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic hoe_reg, hoe_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic busy_reg, busy_next;

	// access sequencing
	always_comb begin
		state_next = state_reg;
		strobe_next = strobe_reg;
		read_next = read_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		hoe_next = hoe_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		busy_next = busy_reg;
		case (state_reg)
			HS_IDLE: begin
				// address and select set with strobe
				if (cmd_write || cmd_read) begin
					read_next = cmd_read;
					addr_next = cmd_addr;
					wdata_next = cmd_wdata;
					hoe_next = !cmd_read;
					strobe_next = 1'b0;
					busy_next = 1'b1;
					state_next = HS_HOLD;
				end
			end
			HS_HOLD: begin
				// device answers one edge after it sees the strobe
				state_next = HS_WAIT;
			end
			HS_WAIT: begin
				// wait states while ready is low
				if (bus.ready) begin
					strobe_next = 1'b1;
					state_next = HS_END;
					if (read_reg) begin
						rdata_next = bus.data_bus;
						rvalid_next = 1'b1;
					end
				end
			end
			HS_END: begin
				// write data outlives the rising strobe by a cycle
				hoe_next = 1'b0;
				busy_next = 1'b0;
				state_next = HS_IDLE;
			end
			default: begin
				state_next = HS_IDLE;
			end
		endcase
	end

	// registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= HS_IDLE;
			strobe_reg <= 1'b1;
			read_reg <= 1'b1;
			addr_reg <= 3'h0;
			wdata_reg <= 8'h00;
			hoe_reg <= 1'b0;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			strobe_reg <= strobe_next;
			read_reg <= read_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			hoe_reg <= hoe_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			busy_reg <= busy_next;
		end
	end

	assign bus.access_strobe_n = strobe_reg;
	assign bus.read_select = read_reg;
	assign bus.addr = addr_reg;
	assign bus.host_data_out = wdata_reg;
	assign bus.host_data_oe = hoe_reg;
	assign rd_data = rdata_reg;
	assign rd_valid = rvalid_reg;
	assign busy = busy_reg;
endmodule // scan_port_host

/* scan_port_host_assertions.sv */
// watches the parallel host bus between the two ends
module scan_port_host_assertions (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic access_strobe_n,
	input wire logic read_select,
	input wire logic [2:0] addr,
	input wire logic host_data_oe,
	input wire logic [7:0] dev_data_out,
	input wire logic dev_data_oe,
	input wire logic ready
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// strobe just went low for a read of a never-blocking place
	sequence read_start;
		$fell(access_strobe_n) && read_select && addr != 3'h5;
	endsequence
	// strobe low on two edges in a row, so the access is settled
	sequence held_low;
		!access_strobe_n && !$past(access_strobe_n);
	endsequence
	drivers_idle_a: assert property (access_strobe_n && $past(access_strobe_n) |-> !dev_data_oe)
		else $error("device drives with strobe high");
	write_no_drive_a: assert property (held_low ##0 !read_select |-> !dev_data_oe)
		else $error("device drives during a write");
	read_drive_a: assert property (read_start |-> ##[1:2] dev_data_oe)
		else $error("read data not driven");
	read_stable_a: assert property (dev_data_oe && $past(dev_data_oe) && !access_strobe_n |-> $stable(dev_data_out))
		else $error("read data moved while driven");
	access_dip_a: assert property ($fell(access_strobe_n) |-> ##[0:2] !ready)
		else $error("ready never dipped at access start");
	status_write_a: assert property ($fell(access_strobe_n) && !read_select && addr == 3'h2 |-> ##[2:4] ready)
		else $error("status write stalled");
	release_ready_a: assert property ($rose(access_strobe_n) |-> $past(ready))
		else $error("strobe released while not ready");
	addr_hold_a: assert property (held_low |-> $stable(addr) && $stable(read_select))
		else $error("address or select moved under strobe");
	host_drive_a: assert property (held_low ##0 !read_select |-> host_data_oe)
		else $error("host not driving write data");
	no_clash_a: assert property (!(dev_data_oe && host_data_oe))
		else $error("both ends drive the bus");
endmodule // scan_port_host_assertions

/* scan_port_pkg.sv */
// Summary of operation
// - eight data lines, three address lines
// - codes 000-111 select the eight registers
// - accesses timed only by strobe edges
// - host holds select and address during strobe
// - read enables drivers at falling strobe; the device enables them at the second clock edge after it at the earliest
// - drivers released whenever strobe is high; the device releases them at the first clock edge after strobe rises
// - writes never enable device drivers
// - address at falling, data at rising strobe
// - blocked access holds ready low until clear
// - empty incoming buffer stalls its read
// - full or clearing outgoing buffer stalls write
// - running opcode stalls command/config/counter writes
// - soft reset write is never stalled
// - writes lead reads by five at most
// - all readable; status, incoming read only
// - other writes stalled while command runs; outgoing buffer writes are not
// - reserved bits written zero, read zero
// - clock delay resets 0x80, others 0x00
// - status and command show blocking conditions
package scan_port_pkg;
	// register addresses
	localparam logic [2:0] ADDR_CONFIG_MAIN = 3'h0;
	localparam logic [2:0] ADDR_CONFIG_CLOCK_DELAY = 3'h1;
	localparam logic [2:0] ADDR_PORT_STATUS = 3'h2;
	localparam logic [2:0] ADDR_SCAN_COMMAND = 3'h3;
	localparam logic [2:0] ADDR_OUTGOING_BUFFER = 3'h4;
	localparam logic [2:0] ADDR_INCOMING_BUFFER = 3'h5;
	localparam logic [2:0] ADDR_CYCLE_COUNTER = 3'h6;
	localparam logic [2:0] ADDR_DIRECT_PIN_CONTROL = 3'h7;
	// reset values
	localparam logic [7:0] RESET_CLOCK_DELAY = 8'h80;
	localparam logic [7:0] RESET_OTHER = 8'h00;
	// writable bit masks, reserved bits held at zero
	localparam logic [7:0] MASK_CONFIG_MAIN = 8'h3f;
	localparam logic [7:0] MASK_CLOCK_DELAY = 8'hef;
	localparam logic [7:0] MASK_DIRECT_PIN = 8'h0f;
	// field positions
	localparam int SOFT_RESET_BIT = 7;
	localparam int OPCODE_MSB = 3;
	localparam int RETIME_MSB = 3;
	localparam int IN_EMPTY_BIT = 7;
	localparam int OUT_FULL_BIT = 6;
	localparam int COUNTER_STATE_BIT = 5;
	// largest lead of outgoing writes over incoming reads
	localparam logic [2:0] LEAD_LIMIT = 3'h5;
endpackage

/* tb_scan_master_host_port.sv */
// host end and device end joined; user orders go in at the host end
module tb_scan_master_host_port;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock, rst_n, cmd_write, cmd_read, rd_valid, busy, sr_seen;
	logic [2:0] cmd_addr, a;
	logic [7:0] cmd_wdata, rd_data, d;
	// device status inputs, all driven by the bench
	logic in_buffer_empty_flag, out_buffer_full_flag, counter_state_flag;
	logic [1:0] tap_state_field_a, present_state_field;
	logic [7:0] incoming_data;
	logic full_duplex_active, command_done;
	logic [7:0] cfg_main, cfg_delay, scan_cmd, cyc_cnt, pin_ctl, out_data;
	logic out_wr, in_rd, cmd_wr, soft_rst;
	logic [2:0] plain_regs [5] = '{3'h0, 3'h1, 3'h4, 3'h6, 3'h7};
	logic [2:0] held_regs [5] = '{3'h0, 3'h1, 3'h3, 3'h6, 3'h7};
	int n_mismatch = 0;
	int tests_run = 0;
	int seed;
	int n_rv = 0, n_ow = 0, n_ir = 0, n_cw = 0; // pulses seen so far
	int k_ow, k_ir, k_cw; // pulse counts at the start of a test
	scan_host_if bus_if ();
	scan_port_host i_scan_port_host (.clock(clock), .rst_n(rst_n),
		.bus(bus_if), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
		.cmd_write(cmd_write), .cmd_read(cmd_read), .rd_data(rd_data),
		.rd_valid(rd_valid), .busy(busy));
	scan_port_device i_scan_port_device (.clock(clock), .rst_n(rst_n),
		.bus(bus_if), .in_buffer_empty_flag(in_buffer_empty_flag),
		.out_buffer_full_flag(out_buffer_full_flag),
		.counter_state_flag(counter_state_flag),
		.tap_state_field_a(tap_state_field_a),
		.present_state_field(present_state_field),
		.incoming_data(incoming_data),
		.full_duplex_active(full_duplex_active),
		.command_done(command_done), .config_main(cfg_main),
		.config_clock_delay(cfg_delay), .scan_command(scan_cmd),
		.cycle_counter(cyc_cnt), .direct_pin_control(pin_ctl),
		.outgoing_data(out_data), .outgoing_write(out_wr),
		.incoming_read(in_rd), .command_write(cmd_wr),
		.soft_reset(soft_rst));
	scan_port_host_assertions i_chk (.clock(clock), .rst_n(rst_n),
		.access_strobe_n(bus_if.access_strobe_n),
		.read_select(bus_if.read_select), .addr(bus_if.addr),
		.host_data_oe(bus_if.host_data_oe),
		.dev_data_out(bus_if.dev_data_out),
		.dev_data_oe(bus_if.dev_data_oe), .ready(bus_if.ready));
	// writable bits of each register; reserved ones read back zero
	function automatic logic [7:0] exp_mask(input logic [2:0] r);
		case (r)
			3'h0: return scan_port_pkg::MASK_CONFIG_MAIN;
			3'h1: return scan_port_pkg::MASK_CLOCK_DELAY;
			3'h7: return scan_port_pkg::MASK_DIRECT_PIN;
			default: return 8'hff;
		endcase
	endfunction
	// status byte built from the live flags, bit 4 reserved
	function automatic logic [7:0] exp_status();
		return {in_buffer_empty_flag, out_buffer_full_flag,
			counter_state_flag, 1'b0, tap_state_field_a, present_state_field};
	endfunction
	// register copy that the device shows on its side ports
	function automatic logic [7:0] port_of(input logic [2:0] r);
		case (r)
			3'h0: return cfg_main;
			3'h1: return cfg_delay;
			3'h3: return scan_cmd;
			3'h4: return out_data;
			3'h6: return cyc_cnt;
			default: return pin_ctl;
		endcase
	endfunction
	task automatic chk8(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask
	// one order pulse; the host is idle when this is entered
	task automatic start(input logic [2:0] r, input logic w,
		input logic [7:0] v);
		@(posedge clock);
		cmd_addr <= r;
		cmd_wdata <= v;
		cmd_write <= w;
		cmd_read <= !w;
		@(posedge clock);
		cmd_write <= 1'b0;
		cmd_read <= 1'b0;
	endtask
	// bounded wait for the access to end; a hang counts as a mismatch
	task automatic finish;
		int n;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (busy !== 1'b0 && n < 300);
		if (busy !== 1'b0) chk1("busy", 1'b0, busy);
	endtask
	task automatic wr(input logic [2:0] r, input logic [7:0] v);
		start(r, 1'b1, v);
		finish;
	endtask
	task automatic rd_chk(input logic [2:0] r, input logic [7:0] e);
		int k;
		k = n_rv;
		start(r, 1'b0, 8'h00);
		finish;
		chk8($sformatf("reg%0d", r), e, rd_data);
		chk1("rd_valid", 1'b1, n_rv == k + 1);
	endtask
	// a blocked access keeps the host busy and ready low
	task automatic stall_chk;
		repeat (20) @(negedge clock);
		chk1("busy", 1'b1, busy);
		chk1("ready", 1'b0, bus_if.ready);
	endtask
	task automatic pulse_done;
		@(posedge clock) command_done <= 1'b1;
		@(posedge clock) command_done <= 1'b0;
	endtask
	task automatic end_of_test;
		$display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// one-cycle pulses are latched or counted so none is missed
	always @(posedge clock) begin
		if (soft_rst === 1'b1) sr_seen <= 1'b1;
		if (rd_valid === 1'b1) n_rv++;
		if (out_wr === 1'b1) n_ow++;
		if (in_rd === 1'b1) n_ir++;
		if (cmd_wr === 1'b1) n_cw++;
	end
	// watchdog sized well above the expected run
	initial begin
		#600000;
		n_mismatch++;
		end_of_test;
	end
	initial begin
		rst_n = 1'b0;
		{cmd_write, cmd_read, cmd_addr, cmd_wdata} = '0;
		{in_buffer_empty_flag, out_buffer_full_flag, counter_state_flag} = '0;
		{tap_state_field_a, present_state_field, incoming_data} = '0;
		{full_duplex_active, command_done, sr_seen} = '0;
		seed = $urandom(28715);
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) rd_chk(3'(i), i == 1 ? 8'h80 : 8'h00);
		$display("test reset_values done");
		for (int i = 0; i < 25; i++) begin
			a = i < 5 ? plain_regs[i] : plain_regs[$urandom_range(0, 4)];
			d = i < 5 ? 8'hff : 8'($urandom);
			wr(a, d);
			rd_chk(a, d & exp_mask(a));
			chk8("port", d & exp_mask(a), port_of(a));
		end
		$display("test write_readback done");
		for (int i = 0; i < 8; i++) begin
			@(posedge clock) {out_buffer_full_flag, counter_state_flag,
				tap_state_field_a, present_state_field,
				incoming_data} <= 14'($urandom);
			in_buffer_empty_flag <= 1'($urandom);
			wr(3'h2, 8'($urandom));
			rd_chk(3'h2, exp_status());
			@(posedge clock) in_buffer_empty_flag <= 1'b0;
			wr(3'h5, 8'($urandom));
			rd_chk(3'h5, incoming_data);
		end
		$display("test read_only done");
		@(posedge clock) in_buffer_empty_flag <= 1'b1;
		out_buffer_full_flag <= 1'b1;
		incoming_data <= 8'h5a;
		start(3'h5, 1'b0, 8'h00);
		stall_chk;
		@(posedge clock) in_buffer_empty_flag <= 1'b0;
		finish;
		chk8("incoming", 8'h5a, rd_data);
		start(3'h4, 1'b1, 8'ha5);
		stall_chk;
		@(posedge clock) out_buffer_full_flag <= 1'b0;
		finish;
		rd_chk(3'h4, 8'ha5);
		chk8("outgoing", 8'ha5, out_data);
		$display("test buffer_stalls done");
		foreach (held_regs[i]) begin
			d = 8'($urandom) & 8'h70;
			wr(3'h3, 8'h01);
			start(held_regs[i], 1'b1, d);
			stall_chk;
			pulse_done;
			finish;
			rd_chk(held_regs[i], d & exp_mask(held_regs[i]));
		end
		wr(3'h3, 8'h01);
		wr(3'h4, 8'hc3);
		chk8("outgoing", 8'hc3, out_data);
		pulse_done;
		$display("test command_hold done");
		k_cw = n_cw;
		wr(3'h3, 8'h01);
		sr_seen = 1'b0;
		start(3'h3, 1'b1, 8'h80);
		repeat (8) @(negedge clock);
		chk1("busy", 1'b0, busy);
		chk1("soft_reset", 1'b1, sr_seen);
		chk1("command_write", 1'b1, n_cw == k_cw + 2);
		chk8("scan_command", 8'h00, scan_cmd);
		chk8("outgoing", 8'h00, out_data);
		rd_chk(3'h1, 8'h80);
		rd_chk(3'h3, 8'h00);
		$display("test soft_reset done");
		@(posedge clock) full_duplex_active <= 1'b1;
		wr(3'h1, 8'h81);
		k_ow = n_ow;
		k_ir = n_ir;
		for (int i = 0; i < 5; i++) wr(3'h4, 8'(i));
		rd_chk(3'h5, incoming_data);
		chk1("outgoing_write", 1'b1, n_ow == k_ow + 5);
		chk1("incoming_read", 1'b1, n_ir == k_ir + 1);
		wr(3'h4, 8'h3c);
		start(3'h4, 1'b1, 8'h66);
		stall_chk;
		@(posedge clock) full_duplex_active <= 1'b0;
		finish;
		rd_chk(3'h4, 8'h66);
		$display("test lead_limit done");
		end_of_test;
	end
endmodule // tb_scan_master_host_port
